// File: lsd_pkg.sv
// Purpose: shared constants and types of the load/store single decoder
// Assumes: 32-bit instructions arrive as a first and a second halfword
// Notes:   field positions index into the halfword that holds the field
`default_nettype none

package lsd_pkg;

  // --------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------
  localparam int HW_W          = 16;
  localparam int SPACE_MSB     = 15;
  localparam int SPACE_LSB     = 9;
  localparam int TAG_MSB       = 6;
  localparam int TAG_LSB       = 4;
  localparam int LD_MAJOR_MSB  = 8;
  localparam int LD_MAJOR_LSB  = 7;
  localparam int ST_SPACE_LSB  = 8;
  localparam int ST_MAJOR_MSB  = 7;
  localparam int ST_MAJOR_LSB  = 5;
  localparam int ST_TAG_BIT    = 4;
  localparam int LIT_ADD_BIT   = 7;
  localparam int BASE_MSB      = 3;
  localparam int BASE_LSB      = 0;
  localparam int XFER_MSB      = 15;
  localparam int XFER_LSB      = 12;
  localparam int MINOR_MSB     = 11;
  localparam int MINOR_LSB     = 6;
  localparam int IMM12_MSB     = 11;
  localparam int IMM8_MSB      = 7;
  localparam int INDEX_BIT     = 10;
  localparam int ADD_BIT       = 9;
  localparam int WBACK_BIT     = 8;
  localparam int SHIFT_MSB     = 5;
  localparam int SHIFT_LSB     = 4;
  localparam int OFFREG_MSB    = 3;
  localparam int OFFREG_LSB    = 0;

  // --------------------------------------------------------------------
  // space and minor opcode patterns
  // --------------------------------------------------------------------
  localparam logic [6:0] LOAD_SPACE   = 7'h7C;
  localparam logic [2:0] HALF_TAG     = 3'h3;
  localparam logic [2:0] BYTE_TAG     = 3'h1;
  localparam logic [7:0] STORE_SPACE  = 8'hF8;
  localparam logic       STORE_TAG    = 1'h0;
  localparam logic [3:0] PC_FIELD     = 4'hF;
  localparam logic [5:0] MINOR_REG    = 6'h00;
  localparam logic [3:0] MINOR_NEG8   = 4'hC;
  localparam logic [3:0] MINOR_UNPRIV = 4'hE;
  localparam logic [1:0] ST_RESERVED  = 2'h3;

  // --------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------
  typedef enum logic [4:0] {
    LSD_NONE,
    LSD_LOAD_UNSIGNED_HALF,
    LSD_LOAD_UNSIGNED_HALF_UNPRIV,
    LSD_LOAD_SIGNED_HALF,
    LSD_LOAD_SIGNED_HALF_UNPRIV,
    LSD_LOAD_UNSIGNED_BYTE,
    LSD_LOAD_UNSIGNED_BYTE_UNPRIV,
    LSD_LOAD_SIGNED_BYTE,
    LSD_LOAD_SIGNED_BYTE_UNPRIV,
    LSD_DATA_PRELOAD_HINT,
    LSD_INSTRUCTION_PRELOAD_HINT,
    LSD_STORE_BYTE,
    LSD_STORE_HALF,
    LSD_STORE_WORD,
    LSD_NOP,
    LSD_UNPREDICTABLE,
    LSD_UNDEFINED
  } lsd_class_e;

  typedef enum logic [2:0] {
    LSD_FORM_NONE,
    LSD_FORM_LIT,
    LSD_FORM_IMM12,
    LSD_FORM_NEG8,
    LSD_FORM_PUW8,
    LSD_FORM_REG,
    LSD_FORM_UNPRIV,
    LSD_FORM_UNDEF
  } lsd_form_e;

  typedef enum logic [1:0] {
    LSD_SIZE_BYTE,
    LSD_SIZE_HALF,
    LSD_SIZE_WORD
  } lsd_size_e;

endpackage

`default_nettype wire

// File: lsd_store_dec.sv
// Purpose: classifies the single-item store space
// Assumes: caller registers the results
// Notes:   purely combinational
`default_nettype none

module lsd_store_dec (
  input  wire logic [15:0]        hw_first,
  input  wire logic [15:0]        hw_second,
  output var  logic               st_hit,
  output var  lsd_pkg::lsd_size_e st_size,
  output var  lsd_pkg::lsd_form_e st_form
);

  logic [2:0] major;

  // --------------------------------------------------------------------
  // space match and form
  // --------------------------------------------------------------------
  always_comb begin
    major   = hw_first[lsd_pkg::ST_MAJOR_MSB:lsd_pkg::ST_MAJOR_LSB];
    st_hit  = (hw_first[lsd_pkg::SPACE_MSB:lsd_pkg::ST_SPACE_LSB] == lsd_pkg::STORE_SPACE)
              && (hw_first[lsd_pkg::ST_TAG_BIT] == lsd_pkg::STORE_TAG);
    case (major[1:0])
      2'h0:    st_size = lsd_pkg::LSD_SIZE_BYTE;
      2'h1:    st_size = lsd_pkg::LSD_SIZE_HALF;
      default: st_size = lsd_pkg::LSD_SIZE_WORD;
    endcase
    if (major[1:0] == lsd_pkg::ST_RESERVED) begin
      st_form = lsd_pkg::LSD_FORM_UNDEF;
    end else if (major[2]) begin
      st_form = lsd_pkg::LSD_FORM_IMM12;
    end else if (hw_second[lsd_pkg::MINOR_MSB]) begin
      st_form = lsd_pkg::LSD_FORM_PUW8;
    end else begin
      st_form = lsd_pkg::LSD_FORM_REG;
    end
  end

endmodule

`default_nettype wire

// File: lsd_decode.sv
// Purpose: registered decoder for halfword loads, byte loads and stores
// Assumes: instruction words come from logic on the same clock
// Notes:   one cycle from instr_valid to dec_valid
//
// Contract
// - halfword, major 0x, base pc: literal unsigned
// - major 00, minor 000000: unsigned halfword register
// - major 00, minor 1110xx: unprivileged unsigned halfword
// - halfword with transfer pc: listed cases NOP
// - signed halfword immediate forms decode correctly
// - halfword, major 1x, base pc: literal signed
// - major 10, minor 000000: signed halfword register
// - major 10, minor 1110xx: unprivileged signed halfword
// - byte, major 0x, base pc: literal unsigned
// - unsigned byte immediate forms decode correctly
// - byte major 00, 1110xx: unprivileged unsigned
// - byte major 00, 000000: unsigned register offset
// - byte, major 1x, base pc: literal signed
// - signed byte immediate, register, unprivileged forms
// - transfer pc listed byte cases: data preload
// - transfer pc listed byte cases: instruction preload
// - store byte immediate and register forms
// - store halfword immediate and register forms
// - store word immediate and register forms
// - unmatched encodings in these spaces flag undefined
`default_nettype none

module lsd_decode (
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic                ce,
  input  wire logic                instr_valid,
  input  wire logic [15:0]         instr_first,
  input  wire logic [15:0]         instr_second,
  output var  logic                dec_valid,
  output var  logic                dec_hit,
  output var  lsd_pkg::lsd_class_e dec_class,
  output var  lsd_pkg::lsd_form_e  dec_form,
  output var  lsd_pkg::lsd_size_e  dec_size,
  output var  logic                dec_signed,
  output var  logic                dec_unpriv,
  output var  logic                dec_undefined,
  output var  logic                dec_unpredictable,
  output var  logic [3:0]          dec_base,
  output var  logic [3:0]          dec_xfer,
  output var  logic [3:0]          dec_offset_reg,
  output var  logic [1:0]          dec_shift,
  output var  logic [11:0]         dec_imm,
  output var  logic                dec_index,
  output var  logic                dec_add,
  output var  logic                dec_writeback
);

  // --------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------
  typedef struct packed {
    logic                valid;
    logic                hit;
    lsd_pkg::lsd_class_e cls;
    lsd_pkg::lsd_form_e  form;
    lsd_pkg::lsd_size_e  size;
    logic                sgn;
    logic                unpriv;
    logic                undef;
    logic                unpred;
    logic [3:0]          base;
    logic [3:0]          xfer;
    logic [3:0]          offset_reg;
    logic [1:0]          shift;
    logic [11:0]         imm;
    logic                index;
    logic                add;
    logic                wback;
  } lsd_state_s;

  lsd_state_s state;
  lsd_state_s next_state;

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic lsd_pkg::lsd_form_e lsd_load_form(
    input logic [1:0] major,
    input logic [5:0] minor,
    input logic       base_pc
  );
    lsd_pkg::lsd_form_e f;

    if (base_pc) begin
      f = lsd_pkg::LSD_FORM_LIT;
    end else if (major[0]) begin
      f = lsd_pkg::LSD_FORM_IMM12;
    end else if (minor == lsd_pkg::MINOR_REG) begin
      f = lsd_pkg::LSD_FORM_REG;
    end else if (minor[5:2] == lsd_pkg::MINOR_NEG8) begin
      f = lsd_pkg::LSD_FORM_NEG8;
    end else if (minor[5:2] == lsd_pkg::MINOR_UNPRIV) begin
      f = lsd_pkg::LSD_FORM_UNPRIV;
    end else if (minor[5] && minor[2]) begin
      f = lsd_pkg::LSD_FORM_PUW8;
    end else begin
      f = lsd_pkg::LSD_FORM_UNDEF;
    end
    return f;
  endfunction

  function automatic lsd_pkg::lsd_class_e lsd_load_class(
    input logic half,
    input logic sgn,
    input logic unpriv
  );
    lsd_pkg::lsd_class_e c;

    case ({half, sgn, unpriv})
      3'h0:    c = lsd_pkg::LSD_LOAD_UNSIGNED_BYTE;
      3'h1:    c = lsd_pkg::LSD_LOAD_UNSIGNED_BYTE_UNPRIV;
      3'h2:    c = lsd_pkg::LSD_LOAD_SIGNED_BYTE;
      3'h3:    c = lsd_pkg::LSD_LOAD_SIGNED_BYTE_UNPRIV;
      3'h4:    c = lsd_pkg::LSD_LOAD_UNSIGNED_HALF;
      3'h5:    c = lsd_pkg::LSD_LOAD_UNSIGNED_HALF_UNPRIV;
      3'h6:    c = lsd_pkg::LSD_LOAD_SIGNED_HALF;
      default: c = lsd_pkg::LSD_LOAD_SIGNED_HALF_UNPRIV;
    endcase
    return c;
  endfunction

  // --------------------------------------------------------------------
  // field split
  // --------------------------------------------------------------------
  logic               half_space;
  logic               byte_space;
  logic               load_space;
  logic [1:0]         major;
  logic [5:0]         minor;
  logic [3:0]         base_field;
  logic [3:0]         xfer_field;
  logic               base_pc;
  logic               xfer_pc;
  lsd_pkg::lsd_form_e ld_form;
  lsd_pkg::lsd_class_e ld_class;
  logic               st_hit;
  lsd_pkg::lsd_size_e st_size;
  lsd_pkg::lsd_form_e st_form;

  assign load_space = instr_first[lsd_pkg::SPACE_MSB:lsd_pkg::SPACE_LSB] == lsd_pkg::LOAD_SPACE;
  assign half_space = load_space && (instr_first[lsd_pkg::TAG_MSB:lsd_pkg::TAG_LSB] == lsd_pkg::HALF_TAG);
  assign byte_space = load_space && (instr_first[lsd_pkg::TAG_MSB:lsd_pkg::TAG_LSB] == lsd_pkg::BYTE_TAG);
  assign major      = instr_first[lsd_pkg::LD_MAJOR_MSB:lsd_pkg::LD_MAJOR_LSB];
  assign minor      = instr_second[lsd_pkg::MINOR_MSB:lsd_pkg::MINOR_LSB];
  assign base_field = instr_first[lsd_pkg::BASE_MSB:lsd_pkg::BASE_LSB];
  assign xfer_field = instr_second[lsd_pkg::XFER_MSB:lsd_pkg::XFER_LSB];
  assign base_pc    = base_field == lsd_pkg::PC_FIELD;
  assign xfer_pc    = xfer_field == lsd_pkg::PC_FIELD;
  assign ld_form    = lsd_load_form(major, minor, base_pc);

  lsd_store_dec u_store (
    .hw_first  (instr_first),
    .hw_second (instr_second),
    .st_hit    (st_hit),
    .st_size   (st_size),
    .st_form   (st_form)
  );

  // --------------------------------------------------------------------
  // load space classification
  // --------------------------------------------------------------------
  always_comb begin
    if (ld_form == lsd_pkg::LSD_FORM_UNDEF) begin
      ld_class = lsd_pkg::LSD_UNDEFINED;
    end else if (!xfer_pc) begin
      ld_class = lsd_load_class(
        half_space,
        major[1],
        ld_form == lsd_pkg::LSD_FORM_UNPRIV
      );
    end else if (ld_form == lsd_pkg::LSD_FORM_PUW8 || ld_form == lsd_pkg::LSD_FORM_UNPRIV) begin
      ld_class = lsd_pkg::LSD_UNPREDICTABLE;
    end else if (half_space) begin
      if (ld_form == lsd_pkg::LSD_FORM_LIT && !major[1]) begin
        ld_class = lsd_pkg::LSD_UNPREDICTABLE;
      end else begin
        ld_class = lsd_pkg::LSD_NOP;
      end
    end else if (major[1]) begin
      ld_class = lsd_pkg::LSD_INSTRUCTION_PRELOAD_HINT;
    end else begin
      ld_class = lsd_pkg::LSD_DATA_PRELOAD_HINT;
    end
  end

  // --------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------
  always_comb begin
    next_state            = state;
    next_state.valid      = instr_valid;
    next_state.hit        = half_space || byte_space || st_hit;
    next_state.base       = base_field;
    next_state.xfer       = xfer_field;
    next_state.offset_reg = instr_second[lsd_pkg::OFFREG_MSB:lsd_pkg::OFFREG_LSB];
    next_state.shift      = instr_second[lsd_pkg::SHIFT_MSB:lsd_pkg::SHIFT_LSB];
    next_state.sgn        = 1'b0;
    next_state.unpriv     = 1'b0;
    next_state.cls        = lsd_pkg::LSD_NONE;
    next_state.form       = lsd_pkg::LSD_FORM_NONE;
    next_state.size       = lsd_pkg::LSD_SIZE_BYTE;
    if (half_space || byte_space) begin
      next_state.cls  = ld_class;
      next_state.form = ld_form;
      next_state.size = half_space ? lsd_pkg::LSD_SIZE_HALF : lsd_pkg::LSD_SIZE_BYTE;
      next_state.sgn  = major[1];
    end else if (st_hit) begin
      next_state.form = st_form;
      case (st_size)
        lsd_pkg::LSD_SIZE_BYTE: begin
          next_state.cls = lsd_pkg::LSD_STORE_BYTE;
        end
        lsd_pkg::LSD_SIZE_HALF: begin
          next_state.cls = lsd_pkg::LSD_STORE_HALF;
        end
        default: begin
          next_state.cls = lsd_pkg::LSD_STORE_WORD;
        end
      endcase
      if (st_form == lsd_pkg::LSD_FORM_UNDEF) begin
        next_state.cls = lsd_pkg::LSD_UNDEFINED;
      end
      next_state.size = st_size;
    end
    next_state.unpred = next_state.cls == lsd_pkg::LSD_UNPREDICTABLE;
    next_state.undef  = next_state.cls == lsd_pkg::LSD_UNDEFINED || next_state.unpred;
    next_state.unpriv = next_state.form == lsd_pkg::LSD_FORM_UNPRIV;

    // ----------------------------------------------------------------
    // offset fields per addressing form
    // ----------------------------------------------------------------
    next_state.imm   = 12'h000;
    next_state.index = 1'b1;
    next_state.add   = 1'b1;
    next_state.wback = 1'b0;
    case (next_state.form)
      lsd_pkg::LSD_FORM_LIT: begin
        next_state.imm = instr_second[lsd_pkg::IMM12_MSB:0];
        next_state.add = instr_first[lsd_pkg::LIT_ADD_BIT];
      end
      lsd_pkg::LSD_FORM_IMM12: begin
        next_state.imm = instr_second[lsd_pkg::IMM12_MSB:0];
      end
      lsd_pkg::LSD_FORM_NEG8, lsd_pkg::LSD_FORM_PUW8: begin
        next_state.imm   = {4'h0, instr_second[lsd_pkg::IMM8_MSB:0]};
        next_state.index = instr_second[lsd_pkg::INDEX_BIT];
        next_state.add   = instr_second[lsd_pkg::ADD_BIT];
        next_state.wback = instr_second[lsd_pkg::WBACK_BIT];
      end
      lsd_pkg::LSD_FORM_UNPRIV: begin
        next_state.imm = {4'h0, instr_second[lsd_pkg::IMM8_MSB:0]};
      end
      default: begin
        next_state.imm = 12'h000;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // register
  // --------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= '0;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // --------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------
  // classification
  assign dec_valid         = state.valid;
  assign dec_hit           = state.hit;
  assign dec_class         = state.cls;
  assign dec_form          = state.form;
  assign dec_size          = state.size;
  assign dec_signed        = state.sgn;
  assign dec_unpriv        = state.unpriv;
  assign dec_undefined     = state.undef;
  assign dec_unpredictable = state.unpred;

  // operand fields
  assign dec_base          = state.base;
  assign dec_xfer          = state.xfer;
  assign dec_offset_reg    = state.offset_reg;
  assign dec_shift         = state.shift;
  assign dec_imm           = state.imm;
  assign dec_index         = state.index;
  assign dec_add           = state.add;
  assign dec_writeback     = state.wback;

endmodule

`default_nettype wire

// File: lsd_decode_sva.sv
// Purpose: assertions on the decoder ports
// Assumes: one clock domain, srst synchronous active high
// Notes:   bound to every lsd_decode instance
`default_nettype none

module lsd_decode_sva (
  input wire logic                clock,
  input wire logic                srst,
  input wire logic                ce,
  input wire logic [15:0]         instr_first,
  input wire logic [15:0]         instr_second,
  input wire lsd_pkg::lsd_class_e dec_class,
  input wire logic                dec_undefined
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  // ------------------------------------------------------------------
  // field helpers
  // ------------------------------------------------------------------
  wire       hw  = instr_first[15:9] == 7'h7C && instr_first[6:4] == 3'h3;
  wire       by  = instr_first[15:9] == 7'h7C && instr_first[6:4] == 3'h1;
  wire       st  = instr_first[15:8] == 8'hF8 && !instr_first[4];
  wire       bpc = instr_first[3:0] == 4'hF;
  wire       tpc = instr_second[15:12] == 4'hF;
  wire [1:0] mj  = instr_first[8:7];
  wire [5:0] mn  = instr_second[11:6];

  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  property p_lit_uhalf;
    ce && hw && !mj[1] && bpc && !tpc |=> dec_class == lsd_pkg::LSD_LOAD_UNSIGNED_HALF;
  endproperty
  a_lit_uhalf: assert property (p_lit_uhalf) else $error("literal unsigned half wrong");
  property p_lit_shalf;
    ce && hw && mj[1] && bpc && !tpc |=> dec_class == lsd_pkg::LSD_LOAD_SIGNED_HALF;
  endproperty
  a_lit_shalf: assert property (p_lit_shalf) else $error("literal signed half wrong");
  property p_uhalf_unpriv;
    ce && hw && mj == 2'h0 && mn[5:2] == 4'hE && !bpc && !tpc
      |=> dec_class == lsd_pkg::LSD_LOAD_UNSIGNED_HALF_UNPRIV;
  endproperty
  a_uhalf_unpriv: assert property (p_uhalf_unpriv) else $error("unpriv half wrong");
  property p_half_nop;
    ce && hw && mj[0] && !bpc && tpc |=> dec_class == lsd_pkg::LSD_NOP;
  endproperty
  a_half_nop: assert property (p_half_nop) else $error("half hint not nop");
  property p_pld_lit;
    ce && by && !mj[1] && bpc && tpc |=> dec_class == lsd_pkg::LSD_DATA_PRELOAD_HINT;
  endproperty
  a_pld_lit: assert property (p_pld_lit) else $error("data preload wrong");
  property p_pli_imm;
    ce && by && mj == 2'h3 && !bpc && tpc |=> dec_class == lsd_pkg::LSD_INSTRUCTION_PRELOAD_HINT;
  endproperty
  a_pli_imm: assert property (p_pli_imm) else $error("instruction preload wrong");
  property p_store_word;
    ce && st && instr_first[7:5] == 3'h2 && !mn[5] |=> dec_class == lsd_pkg::LSD_STORE_WORD;
  endproperty
  a_store_word: assert property (p_store_word) else $error("word store wrong");
  property p_store_undef;
    ce && st && instr_first[6:5] == 2'h3 |=> dec_undefined && dec_class == lsd_pkg::LSD_UNDEFINED;
  endproperty
  a_store_undef: assert property (p_store_undef) else $error("store hole not undefined");
  property p_unpred;
    ce && by && !mj[0] && !bpc && tpc && mn[5:2] == 4'hE
      |=> dec_undefined && dec_class == lsd_pkg::LSD_UNPREDICTABLE;
  endproperty
  a_unpred: assert property (p_unpred) else $error("unpredictable byte not flagged");
endmodule

bind lsd_decode lsd_decode_sva u_sva (
  .clock         (clock),
  .srst          (srst),
  .ce            (ce),
  .instr_first   (instr_first),
  .instr_second  (instr_second),
  .dec_class     (dec_class),
  .dec_undefined (dec_undefined)
);

`default_nettype wire

// File: lsd_fetch_model.sv
// Purpose: fetch stage model feeding instruction words
// Assumes: one word per clock when requested
// Notes:   each idle cycle puts the inverse of the current words back on the lines
`default_nettype none

module lsd_fetch_model (
  input  wire logic        clock,
  input  wire logic        req_valid,
  input  wire logic [31:0] req_word,
  output var  logic        instr_valid,
  output var  logic [15:0] instr_first,
  output var  logic [15:0] instr_second
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    instr_valid = 1'b0;
    instr_first = 16'h0000;
    instr_second = 16'h0000;
  end

  // reserved hint words are sent by the directed nop and also by random words with transfer pc
  always @(posedge clock) begin
    instr_valid <= req_valid;
    if (req_valid) begin
      {instr_first, instr_second} <= req_word;
    end else begin
      {instr_first, instr_second} <= ~{instr_first, instr_second};
    end
  end
endmodule

`default_nettype wire

// File: tb_top.sv
// Purpose: self-checking bench for lsd_decode
// Assumes: expected class follows the input words one enabled edge later
// Notes:   directed table, then random words with random ce and a mid reset
`default_nettype none

`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fail_count++; $display("Error at %0t: got %h expected %h", $time, a, b); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock, srst, ce, req_valid, instr_valid, dec_valid, dec_hit, dec_undefined, chk_on;
  logic dec_signed, dec_unpriv, dec_unpredictable, dec_index, dec_add, dec_writeback;
  logic [31:0] req_word, rand_w;
  logic [15:0] instr_first, instr_second;
  logic [3:0] dec_base, dec_xfer, dec_offset_reg;
  logic [1:0] dec_shift;
  logic [11:0] dec_imm;
  lsd_pkg::lsd_class_e dec_class, exp_class;
  lsd_pkg::lsd_form_e dec_form;
  lsd_pkg::lsd_size_e dec_size;
  logic exp_valid, exp_hit, exp_undef, exp_unpred;
  logic [13:0] exp_regs;
  logic [21:0] exp_fields, dec_fields;
  int fail_count, tests_run, cycles, seed, k;

  lsd_fetch_model u_fetch (.clock(clock), .req_valid(req_valid), .req_word(req_word),
    .instr_valid(instr_valid), .instr_first(instr_first), .instr_second(instr_second));

  lsd_decode dut (.clock(clock), .srst(srst), .ce(ce), .instr_valid(instr_valid),
    .instr_first(instr_first), .instr_second(instr_second), .dec_valid(dec_valid),
    .dec_hit(dec_hit), .dec_class(dec_class), .dec_form(dec_form), .dec_size(dec_size),
    .dec_signed(dec_signed), .dec_unpriv(dec_unpriv), .dec_undefined(dec_undefined),
    .dec_unpredictable(dec_unpredictable), .dec_base(dec_base), .dec_xfer(dec_xfer),
    .dec_offset_reg(dec_offset_reg), .dec_shift(dec_shift), .dec_imm(dec_imm), .dec_index(dec_index),
    .dec_add(dec_add), .dec_writeback(dec_writeback));

  assign dec_fields = {dec_form, dec_size, dec_signed, dec_unpriv, dec_imm, dec_index, dec_add, dec_writeback};

  always #5 clock = ~clock;

  // ------------------------------------------------------------------
  // reference model: class code in package enum order
  // ------------------------------------------------------------------
  function automatic int ref_class(input logic [15:0] f, input logic [15:0] s);
    logic b, t, m1, hw, a, pw, up;
    b = f[3:0] == 4'hF;
    t = s[15:12] == 4'hF;
    m1 = f[8];
    hw = f[5];
    a = f[7] || s[11:6] == 6'h00 || s[11:8] == 4'hC;
    pw = s[11] && s[8];
    up = s[11:8] == 4'hE;
    if (f[15:8] == 8'hF8 && !f[4]) return (f[6:5] == 2'h3) ? 16 : 11 + f[6:5];
    if (f[15:9] != 7'h7C || f[6] || !f[4]) return 0;
    if (b && t) return hw ? (m1 ? 14 : 15) : 9 + m1;
    if (b) return 1 + 4 * !hw + 2 * m1;
    if (t) return a ? (hw ? 14 : 9 + m1) : ((up || pw) ? 15 : 16);
    if (a || pw) return 1 + 4 * !hw + 2 * m1;
    return up ? 2 + 4 * !hw + 2 * m1 : 16;
  endfunction

  // reference model: {form, size, signed, unpriv, imm, index, add, writeback}
  function automatic logic [21:0] ref_fields(input logic [15:0] f, input logic [15:0] s);
    logic ld, st;
    logic [2:0] fm;
    logic [14:0] o;
    ld = f[15:9] == 7'h7C && !f[6] && f[4];
    st = f[15:8] == 8'hF8 && !f[4];
    fm = 3'h0;
    if (st) fm = (f[6:5] == 2'h3) ? 3'h7 : f[7] ? 3'h2 : s[11] ? 3'h4 : 3'h5;
    if (ld) fm = (f[3:0] == 4'hF) ? 3'h1 : f[7] ? 3'h2 : (s[11:6] == 6'h00) ? 3'h5 : (s[11:8] == 4'hC) ? 3'h3 :
                 (s[11:8] == 4'hE) ? 3'h6 : (s[11] && s[8]) ? 3'h4 : 3'h7;
    case (fm)
      3'h1: o = {s[11:0], 1'b1, f[7], 1'b0};
      3'h2: o = {s[11:0], 3'h6};
      3'h3, 3'h4: o = {4'h0, s[7:0], s[10:8]};
      3'h6: o = {4'h0, s[7:0], 3'h6};
      default: o = {12'h000, 3'h6};
    endcase
    return {fm, ld ? {1'b0, f[5]} : (st && f[6]) ? 2'h2 : {1'b0, st && f[5]}, ld && f[8], fm == 3'h6, o};
  endfunction

  function automatic logic [31:0] rand_word();
    logic [31:0] w, r;
    w = $random(seed);
    r = $random(seed);
    case (r[1:0])
      2'h0: w[31:16] = {7'h7C, w[24:23], 3'h3, w[19:16]};
      2'h1: w[31:16] = {7'h7C, w[24:23], 3'h1, w[19:16]};
      2'h2: w[31:16] = {8'hF8, w[23:21], 1'b0, w[19:16]};
      default: ;
    endcase
    if (r[2]) w[19:16] = 4'hF;
    if (r[3]) w[15:12] = 4'hF;
    return w;
  endfunction

  // ------------------------------------------------------------------
  // scoreboard
  // ------------------------------------------------------------------
  always @(posedge clock) begin
    if (chk_on) begin
      `CHK(dec_class, exp_class)
      `CHK(dec_class, exp_class)
      `CHK(dec_undefined, exp_undef)
      `CHK(dec_unpredictable, exp_unpred)
      `CHK(dec_hit, exp_hit)
      `CHK(dec_valid, exp_valid)
      `CHK({dec_base, dec_xfer, dec_offset_reg, dec_shift}, exp_regs)
      `CHK(dec_fields, exp_fields)
    end
    k = ref_class(instr_first, instr_second);
    if (srst) begin
      chk_on <= 1'b1;
      exp_class <= lsd_pkg::LSD_NONE;
      {exp_valid, exp_hit, exp_undef, exp_unpred, exp_regs} <= 18'h00000;
      exp_fields <= 22'h000000;
    end else if (ce) begin
      exp_class <= lsd_pkg::lsd_class_e'(k);
      {exp_valid, exp_hit, exp_undef, exp_unpred} <= {instr_valid, k != 0, k >= 15, k == 15};
      exp_regs <= {instr_first[3:0], instr_second[15:12], instr_second[3:0], instr_second[5:4]};
      exp_fields <= ref_fields(instr_first, instr_second);
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      finish_test();
    end
  end

  task automatic send(input logic [31:0] w);
    @(posedge clock);
    req_valid <= 1'b1;
    req_word <= w;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    srst = 1'b1;
    ce = 1'b1;
    req_valid = 1'b0;
    req_word = 32'h0000_0000;
    chk_on = 1'b0;
    seed = 5496;
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    send(32'hF83F_2004);
    send(32'hF8B1_2004); send(32'hF831_2900); send(32'hF831_2C00);
    send(32'hF831_2000); send(32'hF831_2E00);
    send(32'hF831_F000); send(32'hF9B1_F123); send(32'hF93F_F000); send(32'hF931_FC00);
    send(32'hF931_2C00); send(32'hF9BF_2004); send(32'hF931_2000); send(32'hF931_2E00);
    send(32'hF81F_2004); send(32'hF891_2004); send(32'hF811_2C00);
    send(32'hF811_2E00); send(32'hF811_2000); send(32'hF91F_2004);
    send(32'hF9B1_2004); send(32'hF911_2E00); send(32'hF911_2000); send(32'hF911_2900);
    send(32'hF81F_F000); send(32'hF811_FC00); send(32'hF891_F000); send(32'hF811_F000);
    send(32'hF91F_F000); send(32'hF991_F000); send(32'hF911_F000);
    send(32'hF881_2000); send(32'hF801_2800); send(32'hF801_2000);
    send(32'hF8A1_2000); send(32'hF821_2800); send(32'hF821_2000);
    send(32'hF8C1_2000); send(32'hF841_2800); send(32'hF841_2000);
    send(32'hF831_2400); send(32'hF861_2000); send(32'hF8E1_2000);
    send(32'hF831_F900); send(32'hF811_FE00); send(32'hF83F_F000); send(32'hF911_F900);
    for (int i = 0; i < 2000; i++) begin
      rand_w = rand_word();
      @(posedge clock);
      req_valid <= seed[0];
      req_word <= rand_w;
      ce <= seed[1] | seed[2];
      srst <= (i == 900);
    end
    repeat (3) @(posedge clock);
    finish_test();
  end
endmodule

`default_nettype wire
